// ---- rtl/dmpwm_pkg.sv ----
// Purpose: shared constants for the dual motor pulse-width block
// Assumes: 8-bit register bytes, register writes arrive from the serial slave
// Notes: addresses are the serial bus register addresses
package dmpwm_pkg;
  localparam int DMPWM_W = 8;
  localparam logic [7:0] DMPWM_ADDR_DUTY_A = 8'h07;
  localparam logic [7:0] DMPWM_ADDR_DUTY_B = 8'h08;
  localparam logic [7:0] DMPWM_DUTY_RST = 8'h00;
  localparam logic [7:0] DMPWM_CNT_ZERO = 8'h00;
  localparam logic [7:0] DMPWM_CNT_ONE = 8'h01;
  typedef enum logic [0:0] {DMPWM_IDLE, DMPWM_RUN} dmpwm_state_t;
endpackage

// ---- rtl/dmpwm_chan.sv ----
// Purpose: one motor channel: period divider and phase waveform
// Assumes: period count and duty setting are stable register values
// Notes: a zero duty setting gives the near-half default waveform
`timescale 1ns/1ns
module dmpwm_chan
  import dmpwm_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic run,
  input wire logic [7:0] period_count,
  input wire logic [7:0] duty,
  output logic phase
);
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic phase_reg;
  logic phase_next;
  logic [7:0] half;

  // period counter and comparator
  always_comb
  begin
    half = period_count >> 1;
    cnt_next = cnt_reg + DMPWM_CNT_ONE;
    if (!run || cnt_reg + DMPWM_CNT_ONE >= period_count)
    begin
      cnt_next = DMPWM_CNT_ZERO;
    end
    if (!run || period_count == DMPWM_CNT_ZERO)
    begin
      phase_next = 1'b0;
    end
    else if (duty == DMPWM_CNT_ZERO)
    begin
      phase_next = (cnt_next < half);
    end
    else
    begin
      phase_next = (cnt_next < duty);
    end
  end

  // counter restarts from zero whenever the channel is stopped
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_reg <= DMPWM_CNT_ZERO;
      phase_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      phase_reg <= phase_next;
    end
  end

  assign phase = phase_reg;
endmodule

// ---- rtl/dmpwm_top.sv ----
// Purpose: duty settings for two motors and their drive waveforms
// Assumes: serial slave decodes bytes into a write strobe, address and data
// Notes: power_down_n is taken as synchronous to clk
`timescale 1ns/1ns
// Operation
// - each motor keeps its own pulse-width setting driving its own waveform
// - settings load zero at reset and while power_down_n is low
// - setting zero gives about half duty
// - nonzero setting is a count of master clock cycles of high time
// - power_down_n low gives stand-by with counters idle
// - switching period is master clock divided by period count
// - setting A at address 07h, setting B at 08h
// - phase outputs low in power-down or when motor stopped
module dmpwm_top
  import dmpwm_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic power_down_n,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] period_count_a,
  input wire logic [7:0] period_count_b,
  input wire logic motor_on_a,
  input wire logic motor_on_b,
  output logic [7:0] duty_a,
  output logic [7:0] duty_b,
  output logic phase_a,
  output logic phase_b,
  output logic standby
);
  logic [7:0] duty_a_reg;
  logic [7:0] duty_a_next;
  logic [7:0] duty_b_reg;
  logic [7:0] duty_b_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  dmpwm_state_t state_reg;
  dmpwm_state_t state_next;
  logic standby_reg;
  logic standby_next;
  logic hit_a;
  logic hit_b;
  logic run_a;
  logic run_b;

  ////////////////////////////////////////////////////////////////////
  // write decode; a byte is taken only while power_down_n is high
  // the serial slave pulses reg_wr once per byte, but a held strobe
  // is harmless: it just rewrites the same value on every cycle
  always_comb
  begin
    hit_a = 1'b0;
    hit_b = 1'b0;
    if (reg_wr && power_down_n)
    begin
      unique case (reg_addr)
        DMPWM_ADDR_DUTY_A:
        begin
          hit_a = 1'b1;
        end
        DMPWM_ADDR_DUTY_B:
        begin
          hit_b = 1'b1;
        end
        default:
        begin
          // period, pulse and voltage bytes belong to other blocks
          hit_a = 1'b0;
          hit_b = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // duty settings; power-down overrides any write in the same cycle,
  // so no stale setting survives a pass through stand-by
  always_comb
  begin
    duty_a_next = duty_a_reg;
    duty_b_next = duty_b_reg;
    if (!power_down_n)
    begin
      duty_a_next = DMPWM_DUTY_RST;
      duty_b_next = DMPWM_DUTY_RST;
    end
    else
    begin
      if (hit_a)
      begin
        duty_a_next = reg_wdata;
      end
      if (hit_b)
      begin
        duty_b_next = reg_wdata;
      end
    end
  end

  // settings hold until the next write or power-down
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      duty_a_reg <= DMPWM_DUTY_RST;
      duty_b_reg <= DMPWM_DUTY_RST;
    end
    else
    begin
      duty_a_reg <= duty_a_next;
      duty_b_reg <= duty_b_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read path; registered, so data follows the address by one cycle
  // unmapped addresses read as zero instead of echoing a neighbour
  always_comb
  begin
    unique case (reg_addr)
      DMPWM_ADDR_DUTY_A:
      begin
        rdata_next = duty_a_reg;
      end
      DMPWM_ADDR_DUTY_B:
      begin
        rdata_next = duty_b_reg;
      end
      default:
      begin
        rdata_next = DMPWM_DUTY_RST;
      end
    endcase
  end

  // answer register for the serial slave
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdata_reg <= DMPWM_DUTY_RST;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // stand-by state: counters held idle to save activity
  // standby gets its own flop so the pin carries no decode glitch
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      DMPWM_IDLE:
      begin
        state_next = power_down_n ? DMPWM_RUN : DMPWM_IDLE;
      end
      DMPWM_RUN:
      begin
        state_next = power_down_n ? DMPWM_RUN : DMPWM_IDLE;
      end
    endcase
    standby_next = (state_next == DMPWM_IDLE);
  end

  // stand-by is reported while reset holds the block
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= DMPWM_IDLE;
      standby_reg <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      standby_reg <= standby_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // a stopped motor or power-down keeps its phase low; power_down_n is
  // used directly as well, so the phases drop without the state lag
  assign run_a = (state_reg == DMPWM_RUN) && power_down_n && motor_on_a;
  assign run_b = (state_reg == DMPWM_RUN) && power_down_n && motor_on_b;

  ////////////////////////////////////////////////////////////////////
  // one waveform generator per motor; the setting is a raw cycle count,
  // so its step in percent shrinks as the period count grows
  dmpwm_chan u_chan_a (
    .clk(clk),
    .arst_n(arst_n),
    .run(run_a),
    .period_count(period_count_a),
    .duty(duty_a_reg),
    .phase(phase_a)
  );

  dmpwm_chan u_chan_b (
    .clk(clk),
    .arst_n(arst_n),
    .run(run_b),
    .period_count(period_count_b),
    .duty(duty_b_reg),
    .phase(phase_b)
  );

  // every output is a flop, either here or inside a channel
  assign duty_a = duty_a_reg;
  assign duty_b = duty_b_reg;
  assign reg_rdata = rdata_reg;
  assign standby = standby_reg;
endmodule

// ---- sim/dmpwm_chk_sva.sv ----
// Purpose: dmpwm_top port checks
// Assumes: power_down_n sync to clk
// Notes: bound at file foot
`timescale 1ns/1ns
module dmpwm_chk
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic power_down_n,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic motor_on_a,
  input wire logic motor_on_b,
  input wire logic [7:0] duty_a,
  input wire logic [7:0] duty_b,
  input wire logic phase_a,
  input wire logic phase_b,
  input wire logic standby
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // taken writes land one cycle later
  wr_duty_a: assert property (reg_wr && power_down_n && reg_addr == 8'h07
    |=> duty_a == $past(reg_wdata)) else $error("write a");
  wr_other_a: assert property (reg_wr && power_down_n && reg_addr == 8'h08
    |=> duty_b == $past(reg_wdata)) else $error("write b");
  // power-down clears and idles
  pd_clear_a: assert property (!power_down_n |=> duty_a == 8'h00 && duty_b == 8'h00)
    else $error("pd clear");
  pd_stby_a: assert property (!power_down_n |=> standby) else $error("stby");
  // phases allowed two cycles of lag in power-down, one cycle when a motor stops
  pd_low_a: assert property (!power_down_n [*3] |-> !phase_a && !phase_b)
    else $error("pd phase");
  off_low_a: assert property (!motor_on_a [*2] |-> !phase_a) else $error("off");
  // no write, no change; a stopped motor B keeps phase_b low
  hold_a_a: assert property (!reg_wr && power_down_n |=> $stable(duty_a))
    else $error("hold a");
  hold_b_a: assert property (!reg_wr && power_down_n |=> $stable(duty_b))
    else $error("hold b");
  off_low_b_a: assert property (!motor_on_b [*2] |-> !phase_b) else $error("off b");
  // read data follows the address by one cycle
  rd_data_a: assert property (reg_addr == 8'h07 |=> reg_rdata == $past(duty_a))
    else $error("read a");
endmodule
bind dmpwm_top dmpwm_chk dmpwm_chk_inst (.*);

// ---- sim/dmpwm_stage.sv ----
// Purpose: drive stage model, times high and period
// Assumes: phase registered on clk
// Notes: lengths in clk cycles
`timescale 1ns/1ns
module dmpwm_stage
(
  input wire logic clk,
  input wire logic phase,
  output int hi_len,
  output int per_len
);
  logic last = 1'h0;
  int h = 0;
  int p = 0;
  // edge counters
  always @(posedge clk)
  begin
    last <= phase;
    h <= phase ? h + 1 : 0;
    p <= (phase && !last) ? 1 : p + 1;
    if (last && !phase) hi_len <= h;
    if (phase && !last) per_len <= p;
  end
endmodule

// ---- sim/test_dmpwm_top.sv ----
// Purpose: register and waveform tests
// Assumes: period counts 16 and 12
// Notes: waits span whole periods
`timescale 1ns/1ns
module test_dmpwm_top;
  logic clk = 1'h0, arst_n = 1'h0, power_down_n = 1'h1, reg_wr = 1'h0;
  logic motor_on_a = 1'h1, motor_on_b = 1'h1, phase_a, phase_b, standby;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, duty_a, duty_b;
  logic [7:0] period_count_a = 8'h10, period_count_b = 8'h0C;
  logic [7:0] dv [2] = '{8'h01, 8'h08};
  int hl_a, pl_a, hl_b, pl_b, err_total = 0, n_tests = 0;
  dmpwm_top dmpwm_top_inst (.*);
  dmpwm_stage dmpwm_stage_a (.clk, .phase(phase_a), .hi_len(hl_a), .per_len(pl_a));
  dmpwm_stage dmpwm_stage_b (.clk, .phase(phase_b), .hi_len(hl_b), .per_len(pl_b));
  // free-running clock
  initial forever #5 clk = ~clk;
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH %0t %h %h", $time, seen, exp);
    end
  endtask
  // strobe stays up for back-to-back writes
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
  endtask
  task automatic idle(int n);
    @(posedge clk);
    reg_wr <= 1'h0;
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge clk);
    reg_wr <= 1'h0;
    reg_addr <= a;
    idle(1);
    check(reg_rdata, e);
  endtask
  task automatic close_out;
    $display("errors %0d tests %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    arst_n <= 1'h1;
    rd(8'h07, 8'h00);
    rd(8'h10, 8'h00);
    idle(40);
    check(hl_a, 8);
    check(pl_a, 16);
    check(hl_b, 6);
    check(pl_b, 12);
    check(standby, 1'h0);
    foreach (dv[i])
    begin
      wr(8'h07, dv[i]);
      wr(8'h08, 8'h05);
      rd(8'h08, 8'h05);
      idle(40);
      check(hl_a, dv[i]);
      check(hl_b, 5);
      check(duty_a, dv[i]);
    end
    @(posedge clk);
    motor_on_a <= 1'h0;
    period_count_b <= 8'h00;
    idle(3);
    check(phase_a, 1'h0);
    check(phase_b, 1'h0);
    @(posedge clk);
    period_count_b <= 8'h0C;
    motor_on_b <= 1'h0;
    idle(3);
    check(phase_b, 1'h0);
    @(posedge clk) power_down_n <= 1'h0;
    wr(8'h07, 8'h03);
    idle(3);
    check(standby, 1'h1);
    check(duty_b, 8'h00);
    @(posedge clk) power_down_n <= 1'h1;
    rd(8'h07, 8'h00);
    close_out();
  end
  // hang guard, about twelve times the expected run
  initial
  begin
    #20000;
    err_total++;
    close_out();
  end
endmodule
